// *** design/frn_pkg.sv ***
// Package: types and constants for the fault report and recovery node
`default_nettype none
package frn_pkg;
  localparam int AREA_W    = 4;
  localparam int KIND_W    = 3;
  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 16;
  localparam int CHK_W     = 6;
  localparam int WORD_W    = DATA_W + CHK_W;
  localparam int RETRY_D   = 4;
  localparam int PTR_W     = 2;
  localparam int MEM_D     = 16;
  localparam int MEM_AW    = 4;
  localparam int SPARE_W   = 5;
  // Number of bits in a report frame
  localparam int REP_BITS  = AREA_W + KIND_W + 1;
  localparam int CNT_W     = 4;
  // Recovery settle time in cycles, less one
  localparam logic [CNT_W-1:0] ISO_CYC = 4'h3;
  localparam logic [KIND_W-1:0] KIND_OUT_PAR = 3'h1;
  localparam logic [KIND_W-1:0] KIND_BUS_PAR = 3'h2;
  localparam logic [KIND_W-1:0] KIND_ECC_UNC = 3'h3;

  typedef struct packed {
    logic [AREA_W-1:0] area;
    logic [KIND_W-1:0] kind;
    logic              permanent;
  } frn_report_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } frn_req_t;

  typedef enum logic [1:0] {ST_RUN, ST_SEND, ST_ISOLATE, ST_RETRY} frn_state_t;
endpackage : frn_pkg
`default_nettype wire

// *** design/frn_node.sv ***
// Fault report and recovery node: checking, report bus, retry buffer, shadow takeover, ECC memory
// What this block does
// - Detected errors start a report broadcast at once, preempting other work.
// - A report carries faulty area, error kind and permanent or transient flag.
// - After recovery each node stores the report in a software readable log.
// - Reports go on dedicated serial lines, one per memory bus.
// - Each node decodes reports that complete in ST_RUN with no local error pending, and picks its own recovery.
// - Outstanding processor requests are held in an internal buffer for reissue.
// - Transient errors retry all outstanding accesses; single-bit errors return corrected data.
// - Every stored memory word carries a single-error correcting code.
// - A shadow stays off the bus until it goes active; meanwhile its memory takes no writes.
// - A shadow goes active when a permanent report names its partner.
// - After a permanent-error switch, all outstanding accesses are retried.
// - Paired buses share one request at a time, split by address; a survivor takes over the failed bus's traffic.
// - A spare bit per word can replace a failed array bit.
// - All information arriving from a memory bus is parity checked first.
// - Request errors seen at memory are blamed on the memory bus.
// - Outgoing processor control, address and data are checked before the bus.
// - Recovery is all hardware; software is told only when it is done.
// - The faulty area is isolated before recovery proceeds.
`default_nettype none
module frn_node #(
  parameter logic [frn_pkg::AREA_W-1:0] MY_AREA      = 4'h1,
  parameter logic [frn_pkg::AREA_W-1:0] PARTNER_AREA = 4'h2,
  parameter logic [frn_pkg::AREA_W-1:0] BUS0_AREA    = 4'h8,
  parameter logic [frn_pkg::AREA_W-1:0] BUS1_AREA    = 4'h9
) (
  input  wire  logic                       CLK,
  input  wire  logic                       SRST,
  input  wire  logic                       SHADOW_EN,
  input  wire  frn_pkg::frn_req_t          PROC_REQ,
  input  wire  logic                       PROC_PAR,
  input  wire  logic                       PROC_CHK_MISMATCH,
  output logic                             PROC_READY,
  output logic                             PROC_RVALID,
  output logic [frn_pkg::DATA_W-1:0]       PROC_RDATA,
  output frn_pkg::frn_req_t                BUS_REQ,
  output logic                             BUS_PAR,
  output logic                             BUS_SEL,
  input  wire  logic                       BUS_ACK,
  input  wire  logic                       BUS_ACK_PAR,
  input  wire  logic [frn_pkg::SPARE_W-1:0] SPARE_SEL,
  input  wire  logic                       SPARE_EN,
  input  wire  logic [1:0]                 REP_IN,
  output logic [1:0]                       REP_OUT,
  output frn_pkg::frn_report_t             LOG,
  output logic                             LOG_VALID,
  output logic                             ACTIVE,
  output logic [1:0]                       BUS_FAILED
);
  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    frn_pkg::frn_state_t                  st;
    logic [1:0]                           rep_s1;
    logic [1:0]                           rep_s2;
    logic [frn_pkg::REP_BITS-1:0]         rx_sh;
    logic [frn_pkg::CNT_W-1:0]            rx_cnt;
    logic                                 rx_on;
    logic [frn_pkg::REP_BITS-1:0]         tx_sh;
    logic [frn_pkg::CNT_W-1:0]            tx_cnt;
    frn_pkg::frn_report_t                 cur;
    logic [frn_pkg::CNT_W-1:0]            iso_cnt;
    logic                                 active;
    logic [1:0]                           bus_failed;
    logic                                 isolated;
    frn_pkg::frn_report_t                 log_rep;
    logic                                 log_valid;
    frn_pkg::frn_req_t [frn_pkg::RETRY_D-1:0] rbuf;
    logic [frn_pkg::PTR_W-1:0]            head;
    logic [frn_pkg::PTR_W-1:0]            tail;
    logic [frn_pkg::PTR_W:0]              count;
    logic [frn_pkg::PTR_W-1:0]            issue;
    frn_pkg::frn_req_t                    bus_req;
    logic                                 bus_par;
    logic                                 bus_sel;
    logic                                 rvalid;
    logic [frn_pkg::DATA_W-1:0]           rdata;
    logic                                 ready;
    logic [frn_pkg::MEM_D-1:0] [frn_pkg::WORD_W-1:0] mem;
    logic [frn_pkg::MEM_D-1:0]            spare;
    logic [frn_pkg::SPARE_W-1:0]          spare_sel;
    logic                                 spare_en;
  } frn_state_s_t;

  frn_state_s_t s_r;
  frn_state_s_t s_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // Hamming SEC over 16 data bits, positions 1..21 with checks at powers of two
  function automatic logic [frn_pkg::CHK_W-1:0] frn_enc(input logic [frn_pkg::DATA_W-1:0] d);
    logic [frn_pkg::CHK_W-1:0] c;
    int                        di;
    c  = '0;
    di = 0;
    for (int p = 1; p <= frn_pkg::WORD_W - 1; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int k = 0; k < 5; k++) begin
          if (((p >> k) & 1) == 1) begin
            c[k] = c[k] ^ d[di];
          end
        end
        di = di + 1;
      end
    end
    c[5] = ^{d, c[4:0]};
    return c;
  endfunction : frn_enc

  function automatic logic [frn_pkg::DATA_W-1:0] frn_dec(input logic [frn_pkg::WORD_W-1:0] w,
                                                         output logic unc);
    logic [frn_pkg::DATA_W-1:0] d;
    logic [frn_pkg::CHK_W-1:0]  syn;
    int                         di;
    d   = w[frn_pkg::WORD_W-1:frn_pkg::CHK_W];
    syn = frn_enc(d) ^ w[frn_pkg::CHK_W-1:0];
    di  = 0;
    for (int p = 1; p <= frn_pkg::WORD_W - 1; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (syn[4:0] == 5'(p)) begin
          d[di] = ~d[di];
        end
        di = di + 1;
      end
    end
    // Double errors keep a zero overall syndrome with a nonzero position
    unc = (syn[4:0] != 5'h00) && (syn[5] == ^syn[4:0]);
    return d;
  endfunction : frn_dec

  //////////////////////////////////////////////////////////////////////////////
  logic                       out_err;
  logic                       in_err;
  logic                       ecc_unc;
  logic [frn_pkg::WORD_W-1:0] raw_word;
  logic [frn_pkg::DATA_W-1:0] cor_data;
  logic                       rx_done;
  frn_pkg::frn_report_t       rx_rep;
  logic                       rx_bit;
  logic                       rx_start;
  logic [frn_pkg::MEM_AW-1:0] maddr;

  always_comb begin
    s_nxt       = s_r;
    maddr       = s_r.bus_req.addr[frn_pkg::MEM_AW-1:0];
    // Only a request that is being taken is checked; idle fields may hold anything
    out_err     = (PROC_REQ.valid && s_r.ready
                   && (^{PROC_REQ.write, PROC_REQ.addr, PROC_REQ.data, PROC_PAR} != 1'b0))
                  || PROC_CHK_MISMATCH;
    in_err      = s_r.bus_req.valid && BUS_ACK
                  && (^{s_r.bus_req.write, s_r.bus_req.addr, s_r.bus_req.data, BUS_ACK_PAR} != 1'b0);
    raw_word    = s_r.mem[maddr];
    if (s_r.spare_en) begin
      raw_word[s_r.spare_sel] = s_r.spare[maddr];
    end
    ecc_unc     = 1'b0;
    cor_data    = frn_dec(raw_word, ecc_unc);
    // Serial report receive, both lines merged; either bus suffices
    s_nxt.rep_s1 = REP_IN;
    s_nxt.rep_s2 = s_r.rep_s1;
    rx_bit      = |s_r.rep_s2;
    rx_start    = !s_r.rx_on && rx_bit;
    rx_done     = s_r.rx_on && (s_r.rx_cnt == 4'(frn_pkg::REP_BITS - 1));
    rx_rep      = frn_pkg::frn_report_t'({s_r.rx_sh[frn_pkg::REP_BITS-2:0], rx_bit});
    if (rx_start) begin
      s_nxt.rx_on  = 1'b1;
      s_nxt.rx_cnt = '0;
      s_nxt.rx_sh  = '0;
    end else if (s_r.rx_on) begin
      s_nxt.rx_sh  = {s_r.rx_sh[frn_pkg::REP_BITS-2:0], rx_bit};
      s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
      if (rx_done) begin
        s_nxt.rx_on = 1'b0;
      end
    end
    s_nxt.log_valid = 1'b0;
    s_nxt.rvalid    = 1'b0;
    if (PROC_REQ.valid && s_r.ready && !out_err) begin
      s_nxt.rbuf[s_r.tail] = PROC_REQ;
      s_nxt.tail = s_r.tail + 2'h1;
      s_nxt.count = s_nxt.count + 3'h1;
    end
    case (s_r.st)
      frn_pkg::ST_RUN: begin
        if (out_err || in_err || (s_r.bus_req.valid && BUS_ACK && !s_r.bus_req.write && ecc_unc)) begin
          s_nxt.cur.area      = out_err ? MY_AREA : (s_r.bus_sel ? BUS1_AREA : BUS0_AREA);
          s_nxt.cur.kind      = out_err ? frn_pkg::KIND_OUT_PAR
                              : (in_err ? frn_pkg::KIND_BUS_PAR : frn_pkg::KIND_ECC_UNC);
          s_nxt.cur.permanent = PROC_CHK_MISMATCH;
          s_nxt.tx_sh   = s_nxt.cur;
          s_nxt.tx_cnt  = '0;
          s_nxt.bus_req.valid = 1'b0;
          s_nxt.st      = frn_pkg::ST_SEND;
        end else if (rx_done) begin
          s_nxt.cur     = rx_rep;
          s_nxt.st      = frn_pkg::ST_ISOLATE;
          s_nxt.bus_req.valid = 1'b0;
        end else if (s_r.bus_req.valid && BUS_ACK) begin
          if (!s_r.bus_req.write) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = cor_data;
          end else begin
            s_nxt.mem[maddr] = {s_r.bus_req.data, frn_enc(s_r.bus_req.data)};
            if (s_r.spare_en) begin
              s_nxt.spare[maddr] = s_nxt.mem[maddr][s_r.spare_sel];
            end
          end
          s_nxt.head  = s_r.head + 2'h1;
          s_nxt.count = s_nxt.count - 3'h1;
          s_nxt.issue = s_r.head + 2'h1;
          s_nxt.bus_req.valid = 1'b0;
        end else if (!s_r.bus_req.valid && (s_r.issue != s_r.tail || s_r.count == 3'(frn_pkg::RETRY_D))
                     && s_r.count != 3'h0) begin
          s_nxt.bus_req = s_r.rbuf[s_r.issue];
          s_nxt.bus_par = ^{s_r.rbuf[s_r.issue].write, s_r.rbuf[s_r.issue].addr, s_r.rbuf[s_r.issue].data};
          // Even split by address, survivor carries all when its pair failed
          s_nxt.bus_sel = s_r.bus_failed[0] ? 1'b1
                        : (s_r.bus_failed[1] ? 1'b0 : s_r.rbuf[s_r.issue].addr[0]);
        end
      end
      frn_pkg::ST_SEND: begin
        s_nxt.tx_sh  = {s_r.tx_sh[frn_pkg::REP_BITS-2:0], 1'b0};
        s_nxt.tx_cnt = s_r.tx_cnt + 4'h1;
        if (s_r.tx_cnt == 4'(frn_pkg::REP_BITS - 1)) begin
          s_nxt.st = frn_pkg::ST_ISOLATE;
        end
      end
      frn_pkg::ST_ISOLATE: begin
        s_nxt.isolated = 1'b1;
        if (s_r.cur.permanent) begin
          if (SHADOW_EN && (s_r.cur.area == PARTNER_AREA)) begin
            s_nxt.active = 1'b1;
          end
          if (s_r.cur.area == BUS0_AREA) begin
            s_nxt.bus_failed[0] = 1'b1;
          end
          if (s_r.cur.area == BUS1_AREA) begin
            s_nxt.bus_failed[1] = 1'b1;
          end
        end
        s_nxt.iso_cnt = s_r.iso_cnt + 4'h1;
        if (s_r.iso_cnt == frn_pkg::ISO_CYC) begin
          s_nxt.iso_cnt = '0;
          s_nxt.st      = frn_pkg::ST_RETRY;
        end
      end
      frn_pkg::ST_RETRY: begin
        s_nxt.issue     = s_r.head;
        s_nxt.isolated  = 1'b0;
        s_nxt.log_rep   = s_r.cur;
        s_nxt.log_valid = 1'b1;
        s_nxt.st        = frn_pkg::ST_RUN;
      end
      default: begin
        s_nxt.st = frn_pkg::ST_RUN;
      end
    endcase
    // Retry buffer accepts while room remains and no recovery is under way
    // Next-state view, so a buffer that fills this cycle refuses the very next request
    s_nxt.ready = (s_nxt.st == frn_pkg::ST_RUN) && (s_nxt.count < 3'(frn_pkg::RETRY_D)) && !s_nxt.isolated;
    // An inactive shadow never drives a bus request, so none of its accesses completes and its memory takes no writes
    if (SHADOW_EN && !s_r.active) begin
      s_nxt.bus_req.valid = 1'b0;
    end
    if (SPARE_EN && !s_r.spare_en) begin
      s_nxt.spare_sel = SPARE_SEL;
    end
    s_nxt.spare_en = SPARE_EN;
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK) begin
    if (SRST) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      REP_OUT <= 2'h0;
    end else begin
      REP_OUT <= (s_nxt.st == frn_pkg::ST_SEND || (s_r.st == frn_pkg::ST_SEND))
                 ? {2{(s_r.st == frn_pkg::ST_SEND) ? s_r.tx_sh[frn_pkg::REP_BITS-1] : 1'b1}} : 2'h0;
    end
  end

  assign PROC_READY  = s_r.ready;
  assign PROC_RVALID = s_r.rvalid;
  assign PROC_RDATA  = s_r.rdata;
  assign BUS_REQ     = s_r.bus_req;
  assign BUS_PAR     = s_r.bus_par;
  assign BUS_SEL     = s_r.bus_sel;
  assign LOG         = s_r.log_rep;
  assign LOG_VALID   = s_r.log_valid;
  assign ACTIVE      = s_r.active;
  assign BUS_FAILED  = s_r.bus_failed;
endmodule : frn_node
`default_nettype wire

// *** dv/frn_node_sva.sv ***
// Checker: port-level timing properties of the fault report and recovery node
`default_nettype none
module frn_node_sva (
  input wire logic              CLK,
  input wire logic              SRST,
  input wire logic              SHADOW_EN,
  input wire frn_pkg::frn_req_t PROC_REQ,
  input wire logic              PROC_PAR,
  input wire logic              PROC_READY,
  input wire logic              PROC_RVALID,
  input wire frn_pkg::frn_req_t BUS_REQ,
  input wire logic              BUS_PAR,
  input wire logic              BUS_SEL,
  input wire logic              BUS_ACK,
  input wire logic              BUS_ACK_PAR,
  input wire logic [1:0]        REP_OUT,
  input wire logic              LOG_VALID,
  input wire logic              ACTIVE,
  input wire logic [1:0]        BUS_FAILED
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  ////////////////////////////////////////////////////////////////////////
  sequence s_bad_in;
    PROC_REQ.valid && PROC_READY && ^{PROC_PAR, PROC_REQ[32:0]};
  endsequence
  sequence s_bad_ack;
    BUS_REQ.valid && BUS_ACK && (BUS_ACK_PAR ^ (^BUS_REQ[32:0]));
  endsequence
  sequence s_good_rd;
    BUS_REQ.valid && BUS_ACK && !BUS_REQ.write && !(BUS_ACK_PAR ^ (^BUS_REQ[32:0]));
  endsequence
  ////////////////////////////////////////////////////////////////////////
  property p_rep_out; s_bad_in |-> ##[1:2] REP_OUT != 2'h0; endproperty
  property p_rep_bus; s_bad_ack |-> ##[1:2] REP_OUT != 2'h0; endproperty
  // Isolation must hold off new work for three cycles, one fewer than the settle time
  property p_iso; s_bad_in |-> ##2 !PROC_READY [*3]; endproperty
  property p_log; LOG_VALID |-> REP_OUT == 2'h0 ##1 !LOG_VALID; endproperty
  property p_shadow; SHADOW_EN && !ACTIVE |-> !BUS_REQ.valid && !PROC_RVALID; endproperty
  property p_active; ACTIVE |-> SHADOW_EN ##1 ACTIVE; endproperty
  property p_sel;
    BUS_REQ.valid |-> BUS_SEL == (BUS_FAILED[0] ? 1'b1 : (BUS_FAILED[1] ? 1'b0 : BUS_REQ.addr[0]));
  endproperty
  property p_par; BUS_REQ.valid |-> BUS_PAR == ^BUS_REQ[32:0]; endproperty
  property p_hold; BUS_REQ.valid && !BUS_ACK |=> $stable(BUS_REQ); endproperty
  property p_rd; s_good_rd |=> PROC_RVALID; endproperty
  property p_retry; s_bad_ack |-> ##[1:40] BUS_REQ.valid; endproperty
  ////////////////////////////////////////////////////////////////////////
  a_rep_out: assert property (p_rep_out) else $error("no report after bad request");
  a_rep_bus: assert property (p_rep_bus) else $error("no report after bad bus answer");
  a_iso: assert property (p_iso) else $error("ready during isolation");
  a_log: assert property (p_log) else $error("log pulse misplaced");
  a_shadow: assert property (p_shadow) else $error("idle shadow drove outputs");
  a_active: assert property (p_active) else $error("takeover state lost");
  a_sel: assert property (p_sel) else $error("wrong memory bus chosen");
  a_par: assert property (p_par) else $error("bad outgoing parity");
  a_hold: assert property (p_hold) else $error("bus request changed before answer");
  a_rd: assert property (p_rd) else $error("read answer missing");
  a_retry: assert property (p_retry) else $error("no reissue after bus error");
endmodule : frn_node_sva
bind frn_node frn_node_sva u_sva (
  .CLK(CLK), .SRST(SRST), .SHADOW_EN(SHADOW_EN), .PROC_REQ(PROC_REQ), .PROC_PAR(PROC_PAR),
  .PROC_READY(PROC_READY), .PROC_RVALID(PROC_RVALID), .BUS_REQ(BUS_REQ), .BUS_PAR(BUS_PAR),
  .BUS_SEL(BUS_SEL), .BUS_ACK(BUS_ACK), .BUS_ACK_PAR(BUS_ACK_PAR), .REP_OUT(REP_OUT),
  .LOG_VALID(LOG_VALID), .ACTIVE(ACTIVE), .BUS_FAILED(BUS_FAILED));
`default_nettype wire

// *** dv/frn_far_mem.sv ***
// Far-side memory bus model: answers requests, prompt or slow, with echo parity
`default_nettype none
module frn_far_mem (
  input  wire logic              CLK,
  input  wire frn_pkg::frn_req_t BUS_REQ,
  input  wire logic              SLOW,
  input  wire logic              CORRUPT,
  output var  logic              BUS_ACK,
  output var  logic              BUS_ACK_PAR
);
  timeunit 1ns;
  timeprecision 100ps;
  int wait_q = 0;
  initial begin
    BUS_ACK = 1'b0;
    BUS_ACK_PAR = 1'b0;
  end
  always @(posedge CLK) begin
    if (BUS_REQ.valid && !BUS_ACK && wait_q >= (SLOW ? 3 : 0)) begin
      BUS_ACK <= 1'b1;
      BUS_ACK_PAR <= (^BUS_REQ[32:0]) ^ CORRUPT;
      wait_q <= 0;
    end else begin
      BUS_ACK <= 1'b0;
      // Released parity line toggles so a stale value is never mistaken for an answer
      BUS_ACK_PAR <= !BUS_ACK_PAR;
      wait_q <= BUS_REQ.valid ? wait_q + 1 : 0;
    end
  end
endmodule : frn_far_mem
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the fault report and recovery node
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] MY_A = 4'h1, PART_A = 4'h2, BUS0_A = 4'h8, BUS1_A = 4'h9;
  logic clk, srst, shadow_en, proc_par, chk_mis, spare_en, slow, corrupt, proc_ready, proc_rvalid;
  logic bus_par, bus_sel, bus_ack, bus_ack_par, log_valid, active;
  frn_pkg::frn_req_t    proc_req, bus_req;
  frn_pkg::frn_report_t log_rep;
  logic [4:0]  spare_sel;
  logic [1:0]  rep_in, rep_out, bus_failed;
  logic [15:0] proc_rdata;
  logic [15:0] mem [16];
  logic [7:0]  log_q [$], tx_q [$];
  logic [7:0]  tx_bits;
  int err_count, check_count, seed, cycles, tx_n;
  frn_node #(.MY_AREA(MY_A), .PARTNER_AREA(PART_A), .BUS0_AREA(BUS0_A), .BUS1_AREA(BUS1_A)) DUT (
    .CLK(clk), .SRST(srst), .SHADOW_EN(shadow_en), .PROC_REQ(proc_req), .PROC_PAR(proc_par),
    .PROC_CHK_MISMATCH(chk_mis), .PROC_READY(proc_ready), .PROC_RVALID(proc_rvalid), .PROC_RDATA(proc_rdata),
    .BUS_REQ(bus_req), .BUS_PAR(bus_par), .BUS_SEL(bus_sel), .BUS_ACK(bus_ack), .BUS_ACK_PAR(bus_ack_par),
    .SPARE_SEL(spare_sel), .SPARE_EN(spare_en), .REP_IN(rep_in), .REP_OUT(rep_out), .LOG(log_rep),
    .LOG_VALID(log_valid), .ACTIVE(active), .BUS_FAILED(bus_failed));
  frn_far_mem u_far (.CLK(clk), .BUS_REQ(bus_req), .SLOW(slow), .CORRUPT(corrupt), .BUS_ACK(bus_ack),
    .BUS_ACK_PAR(bus_ack_par));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (log_valid === 1'b1) log_q.push_back(log_rep);
    if (bus_ack === 1'b1) corrupt <= 1'b0;
    // Outgoing report frames: start bit, then eight bits MSB first
    if (tx_n > 0) begin
      check(rep_out[1], rep_out[0]);
      tx_bits = {tx_bits[6:0], rep_out[0]};
      tx_n--;
      if (tx_n == 0) tx_q.push_back(tx_bits);
    end else if (rep_out[0] === 1'b1) begin
      tx_n = 8;
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_hi(ref logic sig);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(n < 200, 1);
  endtask : wait_hi
  task automatic do_reset();
    srst = 1'b1;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
  endtask : do_reset
  // Bad requests never reach memory, so the model skips them
  task automatic proc_op(input logic w, input logic [15:0] a, input logic [15:0] d, input logic bad);
    proc_req = '{1'b1, w, a, d};
    proc_par = (^{w, a, d}) ^ bad;
    slow = 1'($random(seed));
    wait_hi(proc_ready);
    @(negedge clk);
    proc_req.valid = 1'b0;
    if (!bad && w) mem[a[3:0]] = d;
    if (!bad && !w) begin
      wait_hi(proc_rvalid);
      check({16'h0, proc_rdata}, {16'h0, mem[a[3:0]]});
    end
    // Let an edge pass so the next call never reasserts valid in the same step
    if (bad || w) @(negedge clk);
  endtask : proc_op
  task automatic send_rep(input int lane, input logic [7:0] frame);
    logic [8:0] bits;
    bits = {1'b1, frame};
    for (int i = 8; i >= 0; i--) begin
      rep_in[lane] = bits[i];
      @(negedge clk);
    end
    rep_in[lane] = 1'b0;
  endtask : send_rep
  task automatic rep_chk(input logic [7:0] exp, input logic [7:0] mask);
    repeat (200) if (log_q.size() == 0) @(negedge clk);
    check(log_q.size(), 1);
    if (log_q.size() > 0) check({24'h0, log_q.pop_front() & mask}, {24'h0, exp & mask});
  endtask : rep_chk
  task automatic tx_chk(input logic [7:0] exp, input logic [7:0] mask);
    check(tx_q.size(), 1);
    if (tx_q.size() > 0) check({24'h0, tx_q.pop_front() & mask}, {24'h0, exp & mask});
  endtask : tx_chk
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 83;
    {srst, shadow_en, proc_par, chk_mis, spare_en, slow, corrupt} = 7'h40;
    {proc_req, spare_sel, rep_in} = '0;
    err_count = 0;
    check_count = 0;
    cycles = 0;
    tx_n = 0;
    do_reset();
    for (int i = 0; i < 16; i++) proc_op(1'b1, {12'($random(seed)), 4'(i)}, 16'($random(seed)), 1'b0);
    for (int i = 0; i < 16; i++) proc_op(1'b0, {12'($random(seed)), 4'(i)}, 16'h0, 1'b0);
    spare_sel = 5'(32'($random(seed) & 32'h7FFF) % 22);
    spare_en = 1'b1;
    for (int i = 0; i < 4; i++) proc_op(1'b0, 16'(i), 16'h0, 1'b0);
    proc_op(1'b1, 16'h0003, ~mem[3], 1'b1);
    rep_chk({MY_A, frn_pkg::KIND_OUT_PAR, 1'b0}, 8'hFF);
    tx_chk({MY_A, frn_pkg::KIND_OUT_PAR, 1'b0}, 8'hFF);
    proc_op(1'b0, 16'h0003, 16'h0, 1'b0);
    corrupt = 1'b1;
    proc_op(1'b0, 16'h0004, 16'h0, 1'b0);
    rep_chk({BUS0_A, frn_pkg::KIND_BUS_PAR, 1'b0}, 8'hFF);
    tx_chk({BUS0_A, frn_pkg::KIND_BUS_PAR, 1'b0}, 8'hFF);
    send_rep(1, {4'h5, frn_pkg::KIND_ECC_UNC, 1'b0});
    rep_chk({4'h5, frn_pkg::KIND_ECC_UNC, 1'b0}, 8'hFF);
    check(active, 1'b0);
    check(tx_q.size(), 0);
    send_rep(0, {BUS0_A, frn_pkg::KIND_BUS_PAR, 1'b1});
    rep_chk({BUS0_A, frn_pkg::KIND_BUS_PAR, 1'b1}, 8'hFF);
    check(bus_failed, 2'h1);
    proc_op(1'b0, 16'h0006, 16'h0, 1'b0);
    chk_mis = 1'b1;
    @(negedge clk);
    chk_mis = 1'b0;
    rep_chk({MY_A, 3'h0, 1'b1}, 8'hF1);
    tx_chk({MY_A, 3'h0, 1'b1}, 8'hF1);
    shadow_en = 1'b1;
    do_reset();
    check(active, 1'b0);
    send_rep(0, {PART_A, frn_pkg::KIND_ECC_UNC, 1'b1});
    rep_chk({PART_A, frn_pkg::KIND_ECC_UNC, 1'b1}, 8'hFF);
    check(active, 1'b1);
    proc_op(1'b1, 16'h0009, 16'($random(seed)), 1'b0);
    proc_op(1'b0, 16'h0009, 16'h0, 1'b0);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
